// >>> tb_timer_channel_regs.sv
// Purpose: self-checking bench for the timer channel register block
// Assumes: read data stands one cycle after the read strobe
// Notes: assertions live in the design; this bench checks at the ports
`include "tcr_cfg.svh"
`default_nettype none

module tb_timer_channel_regs;
   timeunit 1ns;
   timeprecision 1ps;
   localparam logic [7:0] A_SC0 = `TCR_OFFS_CH0_SC;
   localparam logic [7:0] A_VH = `TCR_OFFS_CH0_VH;
   localparam logic [7:0] A_VL = `TCR_OFFS_CH0_VL;
   localparam logic [7:0] A_SC1 = `TCR_OFFS_CH1_SC;
   // compare levels in order: set, toggle, toggle, clear, off
   localparam logic [9:0] CMP_SEQ = 10'h358;
   logic ref_clk_i = 1'b0;
   logic reset_n_i = 1'b0;
   tcr_pkg::tcr_bus_req_type bus_i = '0;
   logic [7:0] rd_data_o;
   logic [15:0] counter_i = 16'h0000;
   logic center_aligned_i = 1'b0;
   logic count_down_i = 1'b0;
   logic period_start_i = 1'b0;
   logic ch0_capture_mode_i = 1'b0;
   logic ch0_capture_i = 1'b0;
   logic [15:0] ch0_value_o;
   logic ch1_match_i = 1'b0;
   logic ch1_pin_i = 1'b0;
   logic ch1_pin_o, ch1_pin_oe_o, ch1_capture_o, ch1_irq_o;
   int n_errors = 0;
   int cmp_count = 0;

   tcr_timer_channel_regs DUT (
      .ref_clk_i(ref_clk_i),
      .reset_n_i(reset_n_i),
      .bus_i(bus_i),
      .rd_data_o(rd_data_o),
      .counter_i(counter_i),
      .center_aligned_i(center_aligned_i),
      .count_down_i(count_down_i),
      .period_start_i(period_start_i),
      .ch0_capture_mode_i(ch0_capture_mode_i),
      .ch0_capture_i(ch0_capture_i),
      .ch0_value_o(ch0_value_o),
      .ch1_match_i(ch1_match_i),
      .ch1_pin_i(ch1_pin_i),
      .ch1_pin_o(ch1_pin_o),
      .ch1_pin_oe_o(ch1_pin_oe_o),
      .ch1_capture_o(ch1_capture_o),
      .ch1_irq_o(ch1_irq_o)
   );

   always #20 ref_clk_i = ~ref_clk_i;

   task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
      cmp_count++;
      if (got !== exp) begin
         n_errors++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk_byte

   task automatic chk_word(input logic [15:0] got, input logic [15:0] exp);
      cmp_count++;
      if (got !== exp) begin
         n_errors++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk_word

   // gap of one cycle between strobes keeps one driver per time step
   task automatic bus_wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge ref_clk_i);
      bus_i <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
      @(posedge ref_clk_i);
      bus_i.wr <= 1'b0;
      @(negedge ref_clk_i);
   endtask : bus_wr

   task automatic bus_rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge ref_clk_i);
      bus_i <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
      @(posedge ref_clk_i);
      bus_i.rd <= 1'b0;
      @(negedge ref_clk_i);
      d = rd_data_o;
   endtask : bus_rd

   // read data must drop back to zero one cycle later
   task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
      logic [7:0] d;
      bus_rd(a, d);
      chk_byte(d, exp);
      @(negedge ref_clk_i);
      chk_byte(rd_data_o, 8'h00);
   endtask : rd_chk

   // k: 0 match, 1 period start, else channel 0 capture of cnt
   task automatic pulse(input int k, input logic [15:0] cnt);
      @(posedge ref_clk_i);
      counter_i <= cnt;
      case (k)
         0: ch1_match_i <= 1'b1;
         1: period_start_i <= 1'b1;
         default: ch0_capture_i <= 1'b1;
      endcase
      @(posedge ref_clk_i);
      ch1_match_i <= 1'b0;
      period_start_i <= 1'b0;
      ch0_capture_i <= 1'b0;
      @(negedge ref_clk_i);
   endtask : pulse

   // c is the capture strobe, sampled in the one cycle it stands
   task automatic pin_to(input logic v, output logic c);
      @(posedge ref_clk_i);
      ch1_pin_i <= v;
      @(posedge ref_clk_i);
      @(negedge ref_clk_i);
      c = ch1_capture_o;
      @(posedge ref_clk_i);
      @(negedge ref_clk_i);
   endtask : pin_to

   function automatic logic exp_cap(input logic [1:0] e, input logic rise);
      return rise ? e[0] : e[1];
   endfunction : exp_cap

   function automatic logic exp_cmp(input logic [1:0] e, input logic p);
      case (e)
         2'h1: return ~p;
         2'h2: return 1'b0;
         2'h3: return 1'b1;
         default: return p;
      endcase
   endfunction : exp_cmp

   // center mode flips the sense of both events of a period
   function automatic logic exp_pwm(input logic c, input logic [1:0] e, input logic h);
      return (e == 2'h2) ^ h ^ c;
   endfunction : exp_pwm

   task automatic test_done;
      $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
      if (n_errors == 0 && cmp_count > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask : test_done

   // tests need well under 3000 cycles
   initial begin
      repeat (20000) @(posedge ref_clk_i);
      n_errors++;
      test_done();
   end

   initial begin
      logic [7:0] d;
      logic [15:0] v, x, cv;
      logic [1:0] e;
      logic p, c;
      v = 16'($urandom(32'h0000_c970));
      cv = 16'h0000;
      p = 1'b0;
      repeat (2) @(posedge ref_clk_i);
      reset_n_i <= 1'b1;
      chk_word(ch0_value_o, 16'h0000);
      bus_wr(8'h20, 8'hff);
      rd_chk(8'h20, 8'h00);
      rd_chk(A_VH, 8'h00);
      rd_chk(A_VL, 8'h00);
      rd_chk(A_SC1, 8'h00);
      $display("test reset done");
      for (int i = 0; i < 6; i++) begin
         v = 16'($urandom);
         bus_wr(i[0] ? A_VL : A_VH, i[0] ? v[7:0] : v[15:8]);
         chk_word(ch0_value_o, cv);
         bus_wr(i[0] ? A_VH : A_VL, i[0] ? v[15:8] : v[7:0]);
         cv = v;
         chk_word(ch0_value_o, cv);
      end
      rd_chk(A_VH, cv[15:8]);
      bus_wr(A_VH, 8'h5a);
      bus_wr(A_SC0, 8'h00);
      bus_wr(A_VL, 8'h3c);
      chk_word(ch0_value_o, cv);
      bus_wr(A_VH, 8'ha5);
      chk_word(ch0_value_o, 16'ha53c);
      $display("test buffered write done");
      @(posedge ref_clk_i);
      ch0_capture_mode_i <= 1'b1;
      v = 16'($urandom);
      x = 16'($urandom);
      pulse(2, v);
      chk_word(ch0_value_o, v);
      rd_chk(A_VH, v[15:8]);
      pulse(2, ~v);
      rd_chk(A_VL, v[7:0]);
      rd_chk(A_VL, ~v[7:0]);
      pulse(2, x);
      bus_wr(A_SC0, 8'h00);
      rd_chk(A_VH, x[15:8]);
      rd_chk(A_VL, x[7:0]);
      // back-to-back pair, a capture lands on the second read
      pulse(2, v);
      @(posedge ref_clk_i);
      bus_i <= '{addr: A_VH, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
      @(posedge ref_clk_i);
      bus_i.addr <= A_VL;
      counter_i <= ~v;
      ch0_capture_i <= 1'b1;
      @(negedge ref_clk_i);
      chk_byte(rd_data_o, v[15:8]);
      @(posedge ref_clk_i);
      bus_i.rd <= 1'b0;
      ch0_capture_i <= 1'b0;
      @(negedge ref_clk_i);
      chk_byte(rd_data_o, v[7:0]);
      chk_word(ch0_value_o, ~v);
      bus_wr(A_VL, v[7:0]);
      chk_word(ch0_value_o, {~v[15:8], v[7:0]});
      @(posedge ref_clk_i);
      ch0_capture_mode_i <= 1'b0;
      $display("test read latch done");
      for (int i = 0; i < 8; i++) begin
         d = (i == 0) ? 8'hff : 8'($urandom);
         bus_wr(A_SC1, d);
         rd_chk(A_SC1, {1'b0, d[6:2], 2'b00});
      end
      bus_wr(A_SC1, 8'h54);
      pulse(0, 16'h0000);
      bus_wr(A_SC1, 8'h54);
      rd_chk(A_SC1, 8'hd4);
      chk_byte({7'h0, ch1_irq_o}, 8'h01);
      pulse(0, 16'h0000);
      bus_wr(A_SC1, 8'h54);
      rd_chk(A_SC1, 8'hd4);
      bus_wr(A_SC1, 8'hd4);
      rd_chk(A_SC1, 8'hd4);
      bus_wr(A_SC1, 8'h14);
      rd_chk(A_SC1, 8'h14);
      chk_byte({7'h0, ch1_irq_o}, 8'h00);
      pulse(0, 16'h0000);
      rd_chk(A_SC1, 8'h94);
      chk_byte({7'h0, ch1_irq_o}, 8'h00);
      bus_wr(A_SC1, 8'h14);
      $display("test flag done");
      for (int k = 0; k < 4; k++) begin
         e = 2'(k);
         for (int r = 1; r >= 0; r--) begin
            bus_wr(A_SC1, {4'h0, e, 2'b00});
            pin_to(r[0], c);
            chk_byte({7'h0, c}, {7'h0, exp_cap(e, r[0])});
            rd_chk(A_SC1, {exp_cap(e, r[0]), 3'b000, e, 2'b00});
            bus_wr(A_SC1, {4'h0, e, 2'b00});
         end
      end
      $display("test capture edge done");
      for (int i = 0; i < 5; i++) begin
         e = CMP_SEQ[9 - 2 * i -: 2];
         bus_wr(A_SC1, {4'h1, e, 2'b00});
         pulse(0, 16'h0000);
         @(negedge ref_clk_i);
         p = exp_cmp(e, p);
         chk_byte({7'h0, ch1_pin_oe_o}, {7'h0, e != 2'h0});
         if (e != 2'h0) chk_byte({7'h0, ch1_pin_o}, {7'h0, p});
      end
      $display("test compare pin done");
      for (int i = 0; i < 4; i++) begin
         e = i[0] ? {i[1], 1'b1} : 2'b10;
         @(posedge ref_clk_i);
         center_aligned_i <= i[1];
         bus_wr(A_SC1, {2'b00, ~i[1], 1'b0, e, 2'b00});
         bus_rd(A_SC1, d);
         bus_wr(A_SC1, {2'b00, ~i[1], 1'b0, e, 2'b00});
         for (int h = 0; h < 2; h++) begin
            @(posedge ref_clk_i);
            count_down_i <= h[0];
            pulse(i[1] ? 0 : 1 - h, 16'h0000);
            @(negedge ref_clk_i);
            chk_byte({7'h0, ch1_pin_o}, {7'h0, exp_pwm(i[1], e, h[0])});
         end
         rd_chk(A_SC1, {2'b10, ~i[1], 1'b0, e, 2'b00});
      end
      @(posedge ref_clk_i);
      center_aligned_i <= 1'b0;
      $display("test pwm done");
      test_done();
   end
endmodule : tb_timer_channel_regs

`default_nettype wire

// >>> tcr_cfg.svh
// Purpose: constants for the timer channel register block
// Assumes: byte-wide plain register port, 8-bit addresses
// Notes: offsets are byte addresses on the register port
`ifndef TCR_CFG_SVH
`define TCR_CFG_SVH

// register offsets
`define TCR_OFFS_CH0_SC 8'h15
`define TCR_OFFS_CH0_VH 8'h16
`define TCR_OFFS_CH0_VL 8'h17
`define TCR_OFFS_CH1_SC 8'h18

// channel 1 status and control bit positions
`define TCR_SC_FLAG_BIT 7
`define TCR_SC_IE_BIT 6
`define TCR_SC_MSH_BIT 5
`define TCR_SC_MSL_BIT 4
`define TCR_SC_ELSH_BIT 3
`define TCR_SC_ELSL_BIT 2

// edge/level select encodings
`define TCR_ELS_OFF 2'h0
`define TCR_ELS_RISE 2'h1
`define TCR_ELS_FALL 2'h2
`define TCR_ELS_BOTH 2'h3

// reset and fill values
`define TCR_BYTE_ZERO 8'h00
`define TCR_WORD_ZERO 16'h0000
`define TCR_RSVD_ZERO 2'h0

`endif

// >>> tcr_pkg.sv
// Purpose: shared types for the timer channel register block
// Assumes: nothing beyond the cfg header
// Notes: no constants here, only types
`default_nettype none

package tcr_pkg;

   typedef enum logic [1:0] {
      TCR_MODE_CAPTURE,
      TCR_MODE_COMPARE,
      TCR_MODE_EDGE_PWM,
      TCR_MODE_CENTER_PWM
   } tcr_mode_type;

   typedef struct packed {
      logic [7:0] addr;
      logic [7:0] wdata;
      logic wr;
      logic rd;
   } tcr_bus_req_type;

   typedef struct packed {
      logic channel_event_flag;
      logic channel_irq_enable;
      logic mode_select_high;
      logic mode_select_low;
      logic [1:0] edge_level_select;
   } tcr_ch1_sc_type;

endpackage : tcr_pkg

`default_nettype wire

// >>> tcr_timer_channel_regs.sv
// Purpose: channel 0 value registers and channel 1 status/control of a 16-bit timer
// Assumes: one clock, inputs synchronous, counter and match strobes come from outside
// Notes: read data stands one cycle after the read strobe
//
// Decided for this implementation: strobed register access.
`include "tcr_cfg.svh"
`default_nettype none

module tcr_timer_channel_regs (
   // clock and reset
   input wire logic ref_clk_i,
   input wire logic reset_n_i,
   // register port
   input wire tcr_pkg::tcr_bus_req_type bus_i,
   output logic [7:0] rd_data_o,
   // counter side
   input wire logic [15:0] counter_i,
   input wire logic center_aligned_i,
   input wire logic count_down_i,
   input wire logic period_start_i,
   // channel 0 side
   input wire logic ch0_capture_mode_i,
   input wire logic ch0_capture_i,
   output logic [15:0] ch0_value_o,
   // channel 1 side
   input wire logic ch1_match_i,
   input wire logic ch1_pin_i,
   output logic ch1_pin_o,
   output logic ch1_pin_oe_o,
   output logic ch1_capture_o,
   output logic ch1_irq_o
);

   function automatic tcr_pkg::tcr_mode_type ch_mode(input logic cpwm, input logic msh,
                                                      input logic msl);
      if (cpwm) begin
         return tcr_pkg::TCR_MODE_CENTER_PWM;
      end else if (msh) begin
         return tcr_pkg::TCR_MODE_EDGE_PWM;
      end else if (msl) begin
         return tcr_pkg::TCR_MODE_COMPARE;
      end
      return tcr_pkg::TCR_MODE_CAPTURE;
   endfunction : ch_mode

   function automatic logic hit(input tcr_pkg::tcr_bus_req_type b, input logic [7:0] offs);
      return b.addr == offs;
   endfunction : hit

   // channel 0 state
   logic [15:0] ch0_value_r;
   logic [15:0] ch0_hold_r;
   logic ch0_latched_r;
   logic ch0_latch_high_r;
   logic [7:0] ch0_wbuf_high_r;
   logic [7:0] ch0_wbuf_low_r;
   logic ch0_high_full_r;
   logic ch0_low_full_r;

   // channel 1 state
   tcr_pkg::tcr_ch1_sc_type ch1_sc_r;
   logic ch1_clear_armed_r;
   logic ch1_pin_prev_r;
   logic ch1_pin_r;

   // decoded strobes
   wire logic ch0_sc_wr = bus_i.wr && hit(bus_i, `TCR_OFFS_CH0_SC);
   wire logic ch0_vh_wr = bus_i.wr && hit(bus_i, `TCR_OFFS_CH0_VH);
   wire logic ch0_vl_wr = bus_i.wr && hit(bus_i, `TCR_OFFS_CH0_VL);
   wire logic ch0_vh_rd = bus_i.rd && hit(bus_i, `TCR_OFFS_CH0_VH);
   wire logic ch0_vl_rd = bus_i.rd && hit(bus_i, `TCR_OFFS_CH0_VL);
   wire logic ch1_sc_wr = bus_i.wr && hit(bus_i, `TCR_OFFS_CH1_SC);
   wire logic ch1_sc_rd = bus_i.rd && hit(bus_i, `TCR_OFFS_CH1_SC);

   // channel 1 mode and events
   tcr_pkg::tcr_mode_type ch1_mode;
   assign ch1_mode = ch_mode(center_aligned_i, ch1_sc_r.mode_select_high,
                             ch1_sc_r.mode_select_low);
   wire logic ch1_rise = ch1_pin_i && !ch1_pin_prev_r;
   wire logic ch1_fall = !ch1_pin_i && ch1_pin_prev_r;
   // edge polarity select, 00 gives none
   wire logic ch1_edge_evt = (ch1_rise && ch1_sc_r.edge_level_select[0]) ||
                             (ch1_fall && ch1_sc_r.edge_level_select[1]);
   wire logic ch1_event = (ch1_mode == tcr_pkg::TCR_MODE_CAPTURE) ? ch1_edge_evt : ch1_match_i;
   // second step of the clear sequence
   wire logic ch1_clear_go = ch1_sc_wr && ch1_clear_armed_r &&
                             !bus_i.wdata[`TCR_SC_FLAG_BIT];
   wire logic ch1_high_true = ch1_sc_r.edge_level_select == `TCR_ELS_FALL;

   always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         ch0_value_r <= `TCR_WORD_ZERO;
      end else if (ch0_capture_mode_i) begin
         // capture mode: direct byte writes, capture wins over software
         if (ch0_capture_i) begin
            ch0_value_r <= counter_i;
         end else if (ch0_vh_wr) begin
            ch0_value_r[15:8] <= bus_i.wdata;
         end else if (ch0_vl_wr) begin
            ch0_value_r[7:0] <= bus_i.wdata;
         end
      end else if (ch0_vh_wr && ch0_low_full_r) begin
         ch0_value_r <= {bus_i.wdata, ch0_wbuf_low_r};
      end else if (ch0_vl_wr && ch0_high_full_r) begin
         ch0_value_r <= {ch0_wbuf_high_r, bus_i.wdata};
      end
   end

   always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         ch0_wbuf_high_r <= `TCR_BYTE_ZERO;
         ch0_wbuf_low_r <= `TCR_BYTE_ZERO;
         ch0_high_full_r <= 1'b0;
         ch0_low_full_r <= 1'b0;
      // control write drops a half pair
      end else if (ch0_sc_wr || ch0_capture_mode_i) begin
         ch0_high_full_r <= 1'b0;
         ch0_low_full_r <= 1'b0;
      end else if (ch0_vh_wr) begin
         ch0_wbuf_high_r <= bus_i.wdata;
         ch0_high_full_r <= !ch0_low_full_r;
         ch0_low_full_r <= 1'b0;
      end else if (ch0_vl_wr) begin
         ch0_wbuf_low_r <= bus_i.wdata;
         ch0_low_full_r <= !ch0_high_full_r;
         ch0_high_full_r <= 1'b0;
      end
   end

   // coherent read latch in capture mode
   always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         ch0_hold_r <= `TCR_WORD_ZERO;
         ch0_latched_r <= 1'b0;
         ch0_latch_high_r <= 1'b0;
      end else if (ch0_sc_wr || !ch0_capture_mode_i) begin
         ch0_latched_r <= 1'b0;
      end else if (ch0_vh_rd || ch0_vl_rd) begin
         if (!ch0_latched_r) begin
            ch0_hold_r <= ch0_value_r;
            ch0_latched_r <= 1'b1;
            ch0_latch_high_r <= ch0_vh_rd;
         end else if (ch0_vh_rd != ch0_latch_high_r) begin
            // the other byte closes the pair
            ch0_latched_r <= 1'b0;
         end
      end
   end

   // channel 1 control fields
   always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         ch1_sc_r.channel_irq_enable <= 1'b0;
         ch1_sc_r.mode_select_high <= 1'b0;
         ch1_sc_r.mode_select_low <= 1'b0;
         ch1_sc_r.edge_level_select <= `TCR_ELS_OFF;
      end else if (ch1_sc_wr) begin
         ch1_sc_r.channel_irq_enable <= bus_i.wdata[`TCR_SC_IE_BIT];
         ch1_sc_r.mode_select_high <= bus_i.wdata[`TCR_SC_MSH_BIT];
         ch1_sc_r.mode_select_low <= bus_i.wdata[`TCR_SC_MSL_BIT];
         ch1_sc_r.edge_level_select <= bus_i.wdata[`TCR_SC_ELSH_BIT:`TCR_SC_ELSL_BIT];
      end
   end

   // channel 1 flag
   always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         ch1_sc_r.channel_event_flag <= 1'b0;
      // event beats a clear in the same cycle
      end else if (ch1_event) begin
         ch1_sc_r.channel_event_flag <= 1'b1;
      // a written 1 never reaches here
      end else if (ch1_clear_go) begin
         ch1_sc_r.channel_event_flag <= 1'b0;
      end
   end

   // first step arms on read of set flag
   always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         ch1_clear_armed_r <= 1'b0;
      end else if (ch1_event || ch1_sc_wr) begin
         ch1_clear_armed_r <= 1'b0;
      end else if (ch1_sc_rd && ch1_sc_r.channel_event_flag) begin
         ch1_clear_armed_r <= 1'b1;
      end
   end

   // pin history for edge detect
   always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         ch1_pin_prev_r <= 1'b0;
      end else begin
         ch1_pin_prev_r <= ch1_pin_i;
      end
   end

   // capture strobe for the channel 1 value registers
   always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         ch1_capture_o <= 1'b0;
      end else begin
         ch1_capture_o <= (ch1_mode == tcr_pkg::TCR_MODE_CAPTURE) && ch1_edge_evt;
      end
   end

   // channel 1 output level
   always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         ch1_pin_r <= 1'b0;
      end else begin
         unique case (ch1_mode)
            tcr_pkg::TCR_MODE_CAPTURE: begin
               ch1_pin_r <= ch1_pin_r;
            end
            tcr_pkg::TCR_MODE_COMPARE: begin
               if (ch1_match_i) begin
                  unique case (ch1_sc_r.edge_level_select)
                     `TCR_ELS_OFF: ch1_pin_r <= ch1_pin_r;
                     `TCR_ELS_RISE: ch1_pin_r <= !ch1_pin_r;
                     `TCR_ELS_FALL: ch1_pin_r <= 1'b0;
                     `TCR_ELS_BOTH: ch1_pin_r <= 1'b1;
                  endcase
               end
            end
            // edge PWM: period start asserts, match ends pulse
            tcr_pkg::TCR_MODE_EDGE_PWM: begin
               if (ch1_match_i) begin
                  ch1_pin_r <= !ch1_high_true;
               end else if (period_start_i) begin
                  ch1_pin_r <= ch1_high_true;
               end
            end
            // center PWM: up-match ends pulse, down-match starts it
            tcr_pkg::TCR_MODE_CENTER_PWM: begin
               if (ch1_match_i) begin
                  ch1_pin_r <= count_down_i ? ch1_high_true : !ch1_high_true;
               end
            end
         endcase
      end
   end

   // pin driven only in output modes with a nonzero field
   always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         ch1_pin_oe_o <= 1'b0;
      end else begin
         ch1_pin_oe_o <= (ch1_sc_r.edge_level_select != `TCR_ELS_OFF) &&
                         (ch1_mode != tcr_pkg::TCR_MODE_CAPTURE);
      end
   end

   // interrupt request, one cycle behind the flag
   always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         ch1_irq_o <= 1'b0;
      end else begin
         ch1_irq_o <= ch1_sc_r.channel_event_flag && ch1_sc_r.channel_irq_enable;
      end
   end

   // read data, valid the cycle after the strobe only
   always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         rd_data_o <= `TCR_BYTE_ZERO;
      end else if (!bus_i.rd) begin
         rd_data_o <= `TCR_BYTE_ZERO;
      end else if (ch0_vh_rd) begin
         rd_data_o <= (ch0_capture_mode_i && ch0_latched_r) ? ch0_hold_r[15:8] :
                      ch0_value_r[15:8];
      end else if (ch0_vl_rd) begin
         rd_data_o <= (ch0_capture_mode_i && ch0_latched_r) ? ch0_hold_r[7:0] :
                      ch0_value_r[7:0];
      end else if (ch1_sc_rd) begin
         rd_data_o <= {ch1_sc_r, `TCR_RSVD_ZERO};
      end else begin
         // unmapped and write-only offsets read zero
         rd_data_o <= `TCR_BYTE_ZERO;
      end
   end

   assign ch0_value_o = ch0_value_r;
   assign ch1_pin_o = ch1_pin_r;

   // checks
   default clocking chk_cb @(posedge ref_clk_i);
   endclocking
   default disable iff (!reset_n_i);
   capture_load_a: assert property (
      ch0_capture_mode_i && ch0_capture_i |=> ch0_value_r == $past(counter_i))
      else $error("capture did not load counter");
   read_freeze_a: assert property (
      ch0_capture_mode_i && ch0_vh_rd && !ch0_latched_r && !ch0_sc_wr
      ##1 ch0_capture_mode_i && ch0_vl_rd && !ch0_sc_wr
      |=> rd_data_o == $past(ch0_hold_r[7:0], 1) && !ch0_latched_r)
      else $error("coherent capture read broken");
   latch_release_a: assert property (ch0_sc_wr |=> !ch0_latched_r)
      else $error("control write left read latch set");
   pair_commit_a: assert property (
      !ch0_capture_mode_i && ch0_high_full_r && ch0_vl_wr
      |=> ch0_value_r == {$past(ch0_wbuf_high_r), $past(bus_i.wdata)})
      else $error("high then low pair not committed");
   pair_discard_a: assert property (
      ch0_sc_wr && !(ch0_capture_mode_i && ch0_capture_i)
      |=> !ch0_high_full_r && !ch0_low_full_r && $stable(ch0_value_r))
      else $error("control write kept half pair");
   reverse_order_a: assert property (
      !ch0_capture_mode_i && ch0_low_full_r && ch0_vh_wr
      |=> ch0_value_r == {$past(bus_i.wdata), $past(ch0_wbuf_low_r)})
      else $error("low then high pair not committed");
   half_pair_hold_a: assert property (
      !ch0_capture_mode_i && !ch0_low_full_r && !ch0_high_full_r && ch0_vh_wr && !ch0_sc_wr
      |=> $stable(ch0_value_r) && ch0_high_full_r)
      else $error("single byte changed active value");
   edge_flag_a: assert property (
      ch1_mode == tcr_pkg::TCR_MODE_CAPTURE && ch1_rise &&
      ch1_sc_r.edge_level_select[0] |=> ch1_sc_r.channel_event_flag)
      else $error("selected edge did not set flag");
   match_flag_a: assert property (
      ch1_mode != tcr_pkg::TCR_MODE_CAPTURE && ch1_match_i |=> ch1_sc_r.channel_event_flag)
      else $error("match did not set flag");
   irq_follow_a: assert property (
      (ch1_sc_r.channel_event_flag && ch1_sc_r.channel_irq_enable) [*2] |-> ch1_irq_o)
      else $error("interrupt missing with flag and enable");
   irq_quiet_a: assert property (!$past(ch1_sc_r.channel_irq_enable) |-> !ch1_irq_o)
      else $error("interrupt with enable clear");
   flag_clear_a: assert property (
      ch1_sc_rd && ch1_sc_r.channel_event_flag && !ch1_event
      ##1 ch1_sc_wr && !bus_i.wdata[`TCR_SC_FLAG_BIT] && !ch1_event
      |=> !ch1_sc_r.channel_event_flag)
      else $error("two-step clear failed");
   clear_restart_a: assert property (
      ch1_event |=> !ch1_clear_armed_r ##0 ch1_sc_r.channel_event_flag)
      else $error("event did not restart clear sequence");
   write_one_a: assert property (
      ch1_sc_r.channel_event_flag && ch1_sc_wr && bus_i.wdata[`TCR_SC_FLAG_BIT]
      |=> ch1_sc_r.channel_event_flag)
      else $error("writing one changed flag");
   unarmed_keep_a: assert property (
      ch1_sc_r.channel_event_flag && !ch1_clear_armed_r && ch1_sc_wr |=>
      ch1_sc_r.channel_event_flag)
      else $error("flag cleared without prior read");
   pwm_level_a: assert property (
      ch1_mode == tcr_pkg::TCR_MODE_EDGE_PWM && ch1_match_i && ch1_high_true |=> !ch1_pin_o)
      else $error("high-true pwm not cleared on match");
   pin_release_a: assert property (
      ch1_sc_r.edge_level_select == `TCR_ELS_OFF |=> !ch1_pin_oe_o)
      else $error("pin driven with field 00");
   reserved_zero_a: assert property (ch1_sc_rd |=> rd_data_o[1:0] == `TCR_RSVD_ZERO)
      else $error("reserved bits not zero");

   cover_clear_seq: cover property (ch1_sc_rd && ch1_sc_r.channel_event_flag ##1 ch1_clear_go);
   cover_pair_write: cover property (
      !ch0_capture_mode_i && ch0_vl_wr ##[1:4] ch0_vh_wr && ch0_low_full_r);
   cover_read_latch: cover property (
      ch0_capture_mode_i && ch0_vl_rd && !ch0_latched_r ##[1:4] ch0_vh_rd);
   cover_center_match: cover property (ch1_mode == tcr_pkg::TCR_MODE_CENTER_PWM && ch1_match_i);

endmodule : tcr_timer_channel_regs

`default_nettype wire
